// file: adapter_pkg.sv
// constants shared by both ends of the parallel adapter host port
// assumes one system clock of 10 MHz drives both ends
package adapter_pkg;
  // widths
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int CTRL_W = 6;
  localparam int CODE_W = 2;
  localparam int NUM_SEC = 2;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  // register select codes
  localparam logic [CODE_W-1:0] CODE_DATA_A = 2'h0;
  localparam logic [CODE_W-1:0] CODE_CTRL_A = 2'h1;
  localparam logic [CODE_W-1:0] CODE_DATA_B = 2'h2;
  localparam logic [CODE_W-1:0] CODE_CTRL_B = 2'h3;
  // control register fields
  localparam int CTRL_REQ1_EN = 0;
  localparam int CTRL_EDGE1_RISE = 1;
  localparam int CTRL_DIR_ACCESS = 2;
  localparam int CTRL_REQ2_EN = 3;
  localparam int CTRL_EDGE2_RISE = 4;
  localparam int CTRL_LINE2_OUT = 5;
  // enable pulse timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int E_CYCLE_NS = 1000;
  localparam int E_HIGH_NS = 450;
  localparam int E_HIGH_CYC = (E_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int E_DIV = (E_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_W = 4;
  // host controller registers
  localparam int SW_ADDR_W = 2;
  localparam int SW_DATA_W = 16;
  localparam logic [SW_ADDR_W-1:0] HOST_ACCESS_OFS = 2'h0;
  localparam logic [SW_ADDR_W-1:0] HOST_STATUS_OFS = 2'h1;
  localparam logic [SW_ADDR_W-1:0] HOST_CONTROL_OFS = 2'h2;
  localparam int ACC_CODE_LSB = 8;
  localparam int ACC_READ = 10;
  localparam int ACC_W = 11;
  localparam int STAT_BUSY = 8;
  localparam int STAT_REQ_A = 9;
  localparam int STAT_REQ_B = 10;
  localparam int CTL_MCLR = 0;
endpackage

// file: adapter_bus_if.sv
// host bus between the adapter and its processor-side master
// assumes both ends run on clk_sys; resolves two-way and open-drain wires
`timescale 1ns/10ps
interface adapter_bus_if;
  import adapter_pkg::*;
  logic enable;
  logic selectHigh0;
  logic selectHigh1;
  logic selectLowN;
  logic regSel0;
  logic regSel1;
  logic readNotWrite;
  logic masterClearN;
  logic [DATA_W-1:0] hostDataHostOut;
  logic hostDataHostOeN;
  logic [DATA_W-1:0] hostDataDevOut;
  logic hostDataDevOeN;
  logic [DATA_W-1:0] hostData;
  logic reqAOut;
  logic reqAOeN;
  logic reqBOut;
  logic reqBOeN;
  logic requestOutSideAN;
  logic requestOutSideBN;

  // data wire: device wins, else host, else pulled up
  assign hostData = !hostDataDevOeN ? hostDataDevOut : (!hostDataHostOeN ? hostDataHostOut : BUS_IDLE);
  // open-drain request wires with pull-up
  assign requestOutSideAN = reqAOeN | reqAOut;
  assign requestOutSideBN = reqBOeN | reqBOut;

  modport host (
    output enable, selectHigh0, selectHigh1, selectLowN, regSel0, regSel1,
    output readNotWrite, masterClearN, hostDataHostOut, hostDataHostOeN,
    input hostData, requestOutSideAN, requestOutSideBN
  );
  modport dev (
    input enable, selectHigh0, selectHigh1, selectLowN, regSel0, regSel1,
    input readNotWrite, masterClearN, hostData, requestOutSideAN, requestOutSideBN,
    output hostDataDevOut, hostDataDevOeN, reqAOut, reqAOeN, reqBOut, reqBOeN
  );
endinterface

// file: adapter_irq_section.sv
// edge-sense, flag pair and request for one section of the adapter
// assumes inputs already synchronised and events one cycle long
`timescale 1ns/10ps
module adapter_irq_section (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // bus events
  input wire logic clearAll,
  input wire logic eFall,
  input wire logic deselFall,
  input wire logic readDataFall,
  // configuration
  input wire logic [adapter_pkg::CTRL_W-1:0] ctrlBits,
  // conditioned interrupt inputs
  input wire logic edgeIn,
  input wire logic lineIn,
  // flags (0: edge input, 1: control line) and request
  output logic [1:0] flags,
  output logic request
);
  import adapter_pkg::*;

  typedef struct packed {
    logic [1:0] prev;
    logic [1:0] flag;
    logic armed;
  } sec_state_t;

  sec_state_t st_q;
  sec_state_t st_d;
  logic [1:0] sample;
  logic [1:0] activeLvl;
  logic [1:0] setEv;

  // next state of the section
  always_comb
  begin
    st_d = st_q;
    sample = {lineIn, edgeIn};
    activeLvl = {ctrlBits[CTRL_EDGE2_RISE], ctrlBits[CTRL_EDGE1_RISE]};
    // conditioned by pulse: prev level only moves at enable falls
    setEv = {2{eFall & st_q.armed}} & (st_q.prev ^ activeLvl) & ~(sample ^ activeLvl)
      & {~ctrlBits[CTRL_LINE2_OUT], 1'b1};
    if (eFall)
    begin
      st_d.prev = sample;
    end
    if (readDataFall)
    begin
      st_d.armed = 1'b0;
    end
    else if (deselFall)
    begin
      st_d.armed = 1'b1;
    end
    // data read clears flags; a set in the same cycle still wins
    st_d.flag = (st_q.flag & {2{~readDataFall}}) | setEv;
    if (clearAll)
    begin
      st_d = '0;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flag;
  assign request = (st_q.flag[0] & ctrlBits[CTRL_REQ1_EN])
    | (st_q.flag[1] & ctrlBits[CTRL_REQ2_EN] & ~ctrlBits[CTRL_LINE2_OUT]);
endmodule

// file: peripheral_adapter_device.sv
// device end of the adapter host port: registers, side A lines, requests
// assumes the host runs on clk_sys and drives the enable pulse
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
module peripheral_adapter_device (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // host bus
  adapter_bus_if.dev bus,
  // side A peripheral lines
  input wire logic [adapter_pkg::PORT_W-1:0] portAPinsIn,
  output logic [adapter_pkg::PORT_W-1:0] portAPinsOut,
  output logic [adapter_pkg::PORT_W-1:0] portAPinsOeN,
  // control lines, used as interrupt inputs here
  input wire logic sideAEdgeIn,
  input wire logic sideAControlLine,
  input wire logic sideBEdgeIn,
  input wire logic sideBControlLine
);
  import adapter_pkg::*;

  localparam int SYNC_W = PORT_W + 2 * NUM_SEC;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    logic ePrev;
    logic [PORT_W-1:0] dirA;
    logic [PORT_W-1:0] outA;
    logic [PORT_W-1:0] dirB;
    logic [PORT_W-1:0] outB;
    logic [NUM_SEC-1:0][CTRL_W-1:0] ctrlLow;
    logic [DATA_W-1:0] rdData;
  } dev_state_t;

  dev_state_t st_q;
  dev_state_t st_d;
  logic selected;
  logic [CODE_W-1:0] code;
  logic eFall;
  logic wrFall;
  logic rdFall;
  logic [NUM_SEC-1:0] dataHit;
  logic [NUM_SEC-1:0] clearFlags;
  logic [NUM_SEC-1:0][1:0] secFlags;
  logic [NUM_SEC-1:0] secReq;
  logic [SYNC_W-1:0] rawIn;
  logic [DATA_W-1:0] readByte;

  assign selected = bus.selectHigh0 & bus.selectHigh1 & ~bus.selectLowN;
  assign code = {bus.regSel1, bus.regSel0};
  // everything keys off the enable pulse
  assign eFall = st_q.ePrev & ~bus.enable;
  // selects assumed stable, so sampling at the fall is safe
  assign wrFall = eFall & selected & ~bus.readNotWrite;
  assign rdFall = eFall & selected & bus.readNotWrite;
  // access bit picks data over direction
  assign dataHit[0] = (code == CODE_DATA_A) & st_q.ctrlLow[0][CTRL_DIR_ACCESS];
  assign dataHit[1] = (code == CODE_DATA_B) & st_q.ctrlLow[1][CTRL_DIR_ACCESS];
  assign clearFlags = {NUM_SEC{rdFall}} & dataHit;
  // pins and control lines enter through one synchroniser
  assign rawIn = {sideBControlLine, sideBEdgeIn, sideAControlLine, sideAEdgeIn, portAPinsIn};

  // read mux, registered every cycle so bus data comes from flops
  always_comb
  begin
    readByte = '0;
    case (code)
      CODE_DATA_A:
      begin
        readByte = dataHit[0] ? st_q.filt[PORT_W-1:0] : st_q.dirA;
      end
      CODE_CTRL_A:
      begin
        readByte = {secFlags[0][0], secFlags[0][1], st_q.ctrlLow[0]};
      end
      CODE_DATA_B:
      begin
        readByte = dataHit[1] ? st_q.outB : st_q.dirB;
      end
      CODE_CTRL_B:
      begin
        readByte = {secFlags[1][0], secFlags[1][1], st_q.ctrlLow[1]};
      end
      default:
      begin
        readByte = '0;
      end
    endcase
  end

  // next state of the device
  always_comb
  begin
    st_d = st_q;
    // three-flop synchroniser; a change counts when stages two and three agree
    st_d.s1 = rawIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.filt = (st_q.s2 & st_q.s3) | (st_q.filt & (st_q.s2 ^ st_q.s3));
    st_d.ePrev = bus.enable;
    st_d.rdData = readByte;
    if (wrFall)
    begin
      case (code)
        CODE_DATA_A:
        begin
          if (dataHit[0])
          begin
            st_d.outA = bus.hostData;
          end
          else
          begin
            st_d.dirA = bus.hostData;
          end
        end
        CODE_CTRL_A:
        begin
          st_d.ctrlLow[0] = bus.hostData[CTRL_W-1:0];
        end
        CODE_DATA_B:
        begin
          if (dataHit[1])
          begin
            st_d.outB = bus.hostData;
          end
          else
          begin
            st_d.dirB = bus.hostData;
          end
        end
        CODE_CTRL_B:
        begin
          st_d.ctrlLow[1] = bus.hostData[CTRL_W-1:0];
        end
        default:
        begin
          st_d.ctrlLow = st_q.ctrlLow;
        end
      endcase
    end
    // master clear; synchroniser keeps running as it holds no setting
    if (!bus.masterClearN)
    begin
      st_d.dirA = '0;
      st_d.outA = '0;
      st_d.dirB = '0;
      st_d.outB = '0;
      st_d.ctrlLow = '0;
      st_d.rdData = '0;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // one flag pair per section
  for (genvar s = 0; s < NUM_SEC; s++)
  begin : g_sec
    adapter_irq_section u_sec (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clearAll(~bus.masterClearN),
      .eFall(eFall),
      .deselFall(eFall & ~selected),
      .readDataFall(clearFlags[s]),
      .ctrlBits(st_q.ctrlLow[s]),
      .edgeIn(st_q.filt[PORT_W + 2 * s]),
      .lineIn(st_q.filt[PORT_W + 2 * s + 1]),
      .flags(secFlags[s]),
      .request(secReq[s])
    );
  end

  // bus drivers
  assign bus.hostDataDevOut = st_q.rdData;
  // on only with select, read, enable
  assign bus.hostDataDevOeN = ~(selected & bus.readNotWrite & bus.enable);
  assign bus.reqAOut = 1'b0;
  assign bus.reqBOut = 1'b0;
  assign bus.reqAOeN = ~secReq[0];
  assign bus.reqBOeN = ~secReq[1];
  assign portAPinsOut = st_q.outA;
  assign portAPinsOeN = ~st_q.dirA;
endmodule

// file: peripheral_adapter_host.sv
// host end: makes the enable pulse and runs one bus access per pulse
// assumes software on a plain strobe port; device on clk_sys too
`timescale 1ns/10ps
module peripheral_adapter_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // adapter bus
  adapter_bus_if.host bus,
  // software port
  input wire logic [adapter_pkg::SW_ADDR_W-1:0] swAddr,
  input wire logic [adapter_pkg::SW_DATA_W-1:0] swWrData,
  input wire logic swWrite,
  input wire logic swRead,
  output logic [adapter_pkg::SW_DATA_W-1:0] swRdData
);
  import adapter_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic e;
    logic pending;
    logic [ACC_W-1:0] cmd;
    logic inFlight;
    logic rnw;
    logic [CODE_W-1:0] code;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdByte;
    logic mclr;
    logic [SW_DATA_W-1:0] rdData;
  } host_state_t;

  // leave reset in the last phase, so the first enable pulse is full width
  localparam host_state_t RESET_ST = '{phase: PHASE_W'(E_DIV - 1), default: '0};

  host_state_t st_q;
  host_state_t st_d;
  logic lastPhase;
  logic [PHASE_W-1:0] nextPhase;

  assign lastPhase = st_q.phase == PHASE_W'(E_DIV - 1);
  assign nextPhase = lastPhase ? '0 : st_q.phase + 1'b1;

  always_comb
  begin
    st_d = st_q;
    st_d.phase = nextPhase;
    st_d.e = nextPhase < PHASE_W'(E_HIGH_CYC);
    // bus held steady for a whole period
    if (lastPhase)
    begin
      st_d.inFlight = st_q.pending;
      st_d.rnw = ~st_q.pending | st_q.cmd[ACC_READ];
      st_d.code = st_q.cmd[ACC_CODE_LSB +: CODE_W];
      st_d.wdata = st_q.cmd[DATA_W-1:0];
      st_d.pending = 1'b0;
    end
    // last high cycle: device data has settled
    if (st_q.phase == PHASE_W'(E_HIGH_CYC - 1) && st_q.inFlight && st_q.rnw)
    begin
      st_d.rdByte = bus.hostData;
    end
    // new access refused while one is still queued
    if (swWrite && swAddr == HOST_ACCESS_OFS && !st_q.pending)
    begin
      st_d.pending = 1'b1;
      st_d.cmd = swWrData[ACC_W-1:0];
    end
    if (swWrite && swAddr == HOST_CONTROL_OFS)
    begin
      st_d.mclr = swWrData[CTL_MCLR];
    end
    // read data valid only in the cycle after the strobe
    st_d.rdData = '0;
    if (swRead)
    begin
      case (swAddr)
        HOST_STATUS_OFS:
        begin
          st_d.rdData[DATA_W-1:0] = st_q.rdByte;
          st_d.rdData[STAT_BUSY] = st_q.pending | st_q.inFlight;
          st_d.rdData[STAT_REQ_A] = ~bus.requestOutSideAN;
          st_d.rdData[STAT_REQ_B] = ~bus.requestOutSideBN;
        end
        HOST_CONTROL_OFS:
        begin
          st_d.rdData[CTL_MCLR] = st_q.mclr;
        end
        default:
        begin
          st_d.rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= RESET_ST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bus.selectHigh0 = st_q.inFlight;
  assign bus.selectHigh1 = st_q.inFlight;
  assign bus.selectLowN = ~st_q.inFlight;
  assign bus.enable = st_q.e;
  assign bus.regSel0 = st_q.code[0];
  assign bus.regSel1 = st_q.code[1];
  assign bus.readNotWrite = st_q.rnw;
  assign bus.masterClearN = ~st_q.mclr;
  assign bus.hostDataHostOut = st_q.wdata;
  assign bus.hostDataHostOeN = ~(st_q.inFlight & ~st_q.rnw);
  assign swRdData = st_q.rdData;
endmodule

// file: adapter_bus_asserts.sv
// concurrent checks on the adapter bus between the host and device ends
// assumes one clock domain; placed beside the bus interface by the bench
`timescale 1ns/10ps
module adapter_bus_asserts (
  // clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // host-driven bus controls
  input logic enable,
  input logic selectHigh0,
  input logic selectHigh1,
  input logic selectLowN,
  input logic regSel0,
  input logic regSel1,
  input logic readNotWrite,
  input logic masterClearN,
  input logic [adapter_pkg::DATA_W-1:0] hostData,
  // device drives
  input logic hostDataDevOeN,
  input logic reqAOut,
  input logic reqAOeN,
  input logic reqBOut,
  input logic reqBOeN
);
  import adapter_pkg::*;
  logic sel;
  logic fall;
  logic enPrev_q;
  logic accessA_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // selection and enable fall as the device sees them
  assign sel = selectHigh0 && selectHigh1 && !selectLowN;
  assign fall = enPrev_q && !enable;
  // track the side A access bit, so data reads differ from direction reads
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enPrev_q <= 1'b0;
      accessA_q <= 1'b0;
    end
    else
    begin
      enPrev_q <= enable;
      if (!masterClearN)
        accessA_q <= 1'b0;
      else if (fall && sel && !readNotWrite && {regSel1, regSel0} == CODE_CTRL_A)
        accessA_q <= hostData[CTRL_DIR_ACCESS];
    end
  end
  property p_oe_cause;
    !hostDataDevOeN |-> sel && readNotWrite && enable;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data driven outside a read");
  property p_oe_read;
    sel && readNotWrite && enable && masterClearN |-> !hostDataDevOeN;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read without data drive");
  property p_desel;
    !sel |-> hostDataDevOeN;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected device drives data");
  property p_enable_period;
    $rose(enable) |=> enable [*4] ##1 !enable [*5] ##1 enable;
  endproperty
  a_enable_period: assert property (p_enable_period) else $error("enable pulse shape wrong");
  property p_sel_hold;
    enable && $past(enable) |-> $stable({selectHigh0, selectHigh1, selectLowN, regSel0, regSel1, readNotWrite});
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selects moved during enable");
  property p_req_a_od;
    !reqAOeN |-> !reqAOut;
  endproperty
  a_req_a_od: assert property (p_req_a_od) else $error("request A driven high");
  property p_req_b_od;
    !reqBOeN |-> !reqBOut;
  endproperty
  a_req_b_od: assert property (p_req_b_od) else $error("request B driven high");
  property p_mclr;
    !masterClearN [*2] |-> reqAOeN && reqBOeN;
  endproperty
  a_mclr: assert property (p_mclr) else $error("request held through master clear");
  property p_read_clears;
    fall && sel && readNotWrite && {regSel1, regSel0} == CODE_DATA_A && accessA_q |=> reqAOeN [*3];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("data A read left request");
  // main scenarios
  c_write: cover property (fall && sel && !readNotWrite);
  c_read: cover property (fall && sel && readNotWrite);
  c_req_a: cover property (!reqAOeN);
  c_req_b: cover property (!reqBOeN);
endmodule

// file: peripheral_adapter_host_port_tb.sv
// self-checking bench joining host and device ends over the bus interface
// assumes 10 MHz clk_sys; drives the software port and peripheral lines
`timescale 1ns/10ps
module peripheral_adapter_host_port_tb;
  import adapter_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [SW_ADDR_W-1:0] swAddr = '0;
  logic [SW_DATA_W-1:0] swWrData = '0;
  logic swWrite = 1'b0;
  logic swRead = 1'b0;
  logic [SW_DATA_W-1:0] swRdData;
  logic [PORT_W-1:0] portAPinsOut;
  logic [PORT_W-1:0] portAPinsOeN;
  logic [PORT_W-1:0] portAPinsIn;
  logic [PORT_W-1:0] extA = 8'h3C;
  logic [PORT_W-1:0] loadMask = 8'h00;
  logic sideAEdgeIn = 1'b1;
  logic sideAControlLine = 1'b1;
  logic sideBEdgeIn = 1'b1;
  logic sideBControlLine = 1'b1;
  logic [SW_DATA_W-1:0] st;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  adapter_bus_if bus();
  // driven lines show the output register unless loaded low; inputs see the far side
  assign portAPinsIn = ((~portAPinsOeN & portAPinsOut) | (portAPinsOeN & extA)) & ~loadMask;
  always #50 clk_sys = ~clk_sys;
  peripheral_adapter_host peripheral_adapter_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
    .swAddr(swAddr), .swWrData(swWrData), .swWrite(swWrite), .swRead(swRead), .swRdData(swRdData));
  peripheral_adapter_device peripheral_adapter_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
    .portAPinsIn(portAPinsIn), .portAPinsOut(portAPinsOut), .portAPinsOeN(portAPinsOeN),
    .sideAEdgeIn(sideAEdgeIn), .sideAControlLine(sideAControlLine), .sideBEdgeIn(sideBEdgeIn),
    .sideBControlLine(sideBControlLine));
  adapter_bus_asserts adapter_bus_asserts_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .enable(bus.enable),
    .selectHigh0(bus.selectHigh0), .selectHigh1(bus.selectHigh1), .selectLowN(bus.selectLowN),
    .regSel0(bus.regSel0), .regSel1(bus.regSel1), .readNotWrite(bus.readNotWrite),
    .masterClearN(bus.masterClearN), .hostData(bus.hostData), .hostDataDevOeN(bus.hostDataDevOeN),
    .reqAOut(bus.reqAOut), .reqAOeN(bus.reqAOeN), .reqBOut(bus.reqBOut), .reqBOeN(bus.reqBOeN));
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // software port: one-cycle strobes, read data taken in the cycle after
  task automatic swWr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    swAddr <= a;
    swWrData <= d;
    swWrite <= 1'b1;
    @(posedge clk_sys);
    swWrite <= 1'b0;
  endtask
  task automatic swRd(input logic [1:0] a);
    @(posedge clk_sys);
    swAddr <= a;
    swRead <= 1'b1;
    @(posedge clk_sys);
    swRead <= 1'b0;
    #1;
    st = swRdData;
    // realign to an edge so later stimulus changes there
    @(posedge clk_sys);
  endtask
  // one adapter access, then poll busy with a bound
  task automatic acc(input logic rd, input logic [1:0] code, input logic [7:0] wd);
    int n = 0;
    swWr(HOST_ACCESS_OFS, {5'h00, rd, code, wd});
    repeat (3) @(posedge clk_sys);
    swRd(HOST_STATUS_OFS);
    while (st[STAT_BUSY] !== 1'b0 && n < 40)
    begin
      n++;
      swRd(HOST_STATUS_OFS);
    end
    // a poll that runs out counts as a mismatch
    if (st[STAT_BUSY] !== 1'b0)
      errors++;
  endtask
  task automatic wr(input logic [1:0] code, input logic [7:0] d);
    acc(1'b0, code, d);
  endtask
  task automatic rdChk(input logic [1:0] code, input logic [7:0] exp);
    acc(1'b1, code, 8'h00);
    check(st[7:0], exp);
  endtask
  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      rdChk(2'(c), 8'h00);
    end
    check(portAPinsOeN, 8'hFF);
    check(8'(bus.requestOutSideAN), 8'h01);
    // unmapped software place
    swWr(2'h3, 16'hFFFF);
    swRd(2'h3);
    check(st[7:0], 8'h00);
    // side A direction, output register and sensed levels
    wr(CODE_DATA_A, 8'hF0);
    wr(CODE_CTRL_A, 8'hFF);
    rdChk(CODE_CTRL_A, 8'h3F);
    wr(CODE_CTRL_A, 8'h04);
    wr(CODE_DATA_A, 8'hA5);
    check(portAPinsOeN, 8'h0F);
    check(portAPinsOut, 8'hA5);
    rdChk(CODE_DATA_A, 8'hAC);
    loadMask <= 8'h20;
    rdChk(CODE_DATA_A, 8'h8C);
    loadMask <= 8'h00;
    wr(CODE_CTRL_A, 8'h00);
    rdChk(CODE_DATA_A, 8'hF0);
    // side B data and direction share code 2
    wr(CODE_DATA_B, 8'h33);
    wr(CODE_CTRL_B, 8'h04);
    wr(CODE_DATA_B, 8'h5A);
    rdChk(CODE_DATA_B, 8'h5A);
    rdChk(CODE_CTRL_B, 8'h04);
    wr(CODE_CTRL_B, 8'h00);
    rdChk(CODE_DATA_B, 8'h33);
    // side A falling edges, both requests enabled
    wr(CODE_CTRL_A, 8'h0D);
    sideAEdgeIn <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check(8'(bus.requestOutSideAN), 8'h00);
    swRd(HOST_STATUS_OFS);
    check(8'(st[STAT_REQ_A]), 8'h01);
    rdChk(CODE_CTRL_A, 8'h8D);
    wr(CODE_CTRL_A, 8'h0D);
    rdChk(CODE_CTRL_A, 8'h8D);
    rdChk(CODE_DATA_A, 8'hAC);
    rdChk(CODE_CTRL_A, 8'h0D);
    check(8'(bus.requestOutSideAN), 8'h01);
    sideAEdgeIn <= 1'b1;
    sideAControlLine <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rdChk(CODE_CTRL_A, 8'h4D);
    check(8'(bus.requestOutSideAN), 8'h00);
    wr(CODE_CTRL_A, 8'h05);
    check(8'(bus.requestOutSideAN), 8'h01);
    // side B rising edge only
    wr(CODE_CTRL_B, 8'h03);
    sideBEdgeIn <= 1'b0;
    sideAControlLine <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rdChk(CODE_CTRL_B, 8'h03);
    sideBEdgeIn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rdChk(CODE_CTRL_B, 8'h83);
    check(8'(bus.requestOutSideBN), 8'h00);
    swRd(HOST_STATUS_OFS);
    check(8'(st[STAT_REQ_B]), 8'h01);
    // run-time master clear
    swWr(HOST_CONTROL_OFS, 16'h0001);
    swRd(HOST_CONTROL_OFS);
    check(st[7:0], 8'h01);
    repeat (20) @(posedge clk_sys);
    swWr(HOST_CONTROL_OFS, 16'h0000);
    check(portAPinsOeN, 8'hFF);
    check(8'(bus.requestOutSideBN), 8'h01);
    rdChk(CODE_CTRL_B, 8'h00);
    rdChk(CODE_DATA_A, 8'h00);
    results();
  end
endmodule
